//--- logic/cbd_bus_debug.v
// cpu bus sizing, harvard arbitration, status mirror and debug port
//
// Overview of operation
// - every bus cycle is one system clock period
// - cycles per access set by device width and access size
// - peripheral registers take 8, 16 and 32 bit accesses
// - 16-bit access to a 16- or 32-bit device completes in one cycle; an 8-bit device takes two
// - 32-bit store forces upper eight bits to zero
// - 32-bit load drops upper eight bits
// - interrupt stacking puts status word in upper byte, address below
// - fetch runs alongside data unless regions conflict; then fetch stretched
// - conflicts: flash/flash, flash/display, ram-or-display/ram-or-display
// - status mirror shows level, enable, c, v, z, n; top byte zero
// - writes to the status mirror change nothing
// - debug base register returns 64-byte work area start; top byte zero
// - debug clock and status outputs start low; data pin bidirectional
// - debug pins are debug pins after reset; software may release them
// - forced break on the data pin raises debug interrupt
// - protected flash: debugger reads undefined, programming errors
// - correct password lifts protection until next reset
`timescale 1ns/10ps
`include "cbd_consts.vh"
module cbd_bus_debug #(
  parameter [23:0] DEBUG_BASE = `CBD_DEBUG_BASE_RST,
  parameter [31:0] UNLOCK_KEY = 32'h1234_5678,
  parameter DBG_CLK_DIV = 4
) (
  input wire CLK_IN,
  input wire RST_IN,
  input wire D_REQ_IN,
  input wire D_WR_IN,
  input wire [1:0] D_SIZE_IN,
  input wire [23:0] D_ADDR_IN,
  input wire [31:0] D_WDATA_IN,
  input wire D_STACK_IN,
  input wire [1:0] D_DEV_IN,
  input wire [1:0] D_RGN_IN,
  input wire [7:0] PSW_IN,
  input wire I_REQ_IN,
  input wire [1:0] I_RGN_IN,
  input wire [31:0] SYS_RDATA_IN,
  input wire DBG_DATA_IN,
  input wire DBG_PINS_RELEASE_IN,
  input wire DBG_ACTIVE_IN,
  input wire [1:0] DBG_STATE_IN,
  input wire DBG_SEND_IN,
  input wire DBG_SEND_BIT_IN,
  input wire DBG_FLASH_RD_IN,
  input wire DBG_FLASH_PROG_IN,
  input wire DBG_KEY_VALID_IN,
  input wire [31:0] DBG_KEY_IN,
  output reg SYS_CYC_OUT,
  output reg SYS_WR_OUT,
  output reg [23:0] SYS_ADDR_OUT,
  output reg [7:0] SYS_WDATA_OUT,
  output reg [3:0] SYS_BE_OUT,
  output reg D_DONE_OUT,
  output reg [23:0] D_RDATA_OUT,
  output reg [7:0] D_STACK_PSW_OUT,
  output reg I_STALL_OUT,
  output reg DBG_CLOCK_OUT,
  output reg DBG_STATE_OUT,
  output reg DBG_DATA_OUT,
  output reg DBG_DATA_OE_OUT,
  output reg DBG_PINS_ACTIVE_OUT,
  output reg DBG_IRQ_OUT,
  output reg FLASH_PROT_OUT,
  output reg [31:0] DBG_FLASH_RDATA_OUT,
  output reg DBG_PROG_ERR_OUT
);
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] beat_ff;
  reg [2:0] beats_ff;
  reg [31:0] wdat_ff;
  reg [31:0] asm_ff;
  reg [23:0] addr_ff;
  reg wr_ff;
  reg [1:0] dev_ff;
  reg stack_ff;
  reg [DBG_CLK_DIV-1:0] div_ff;
  reg brk_ff;
  wire [31:0] mem_rdata;

  function [2:0] beat_count;
    input [1:0] dev;
    input [1:0] sz;
    begin
      case (dev)
        `CBD_DEV_8: beat_count = (sz == `CBD_SZ_32) ? 3'd4 : (sz == `CBD_SZ_16) ? 3'd2 : 3'd1;
        `CBD_DEV_16: beat_count = (sz == `CBD_SZ_32) ? 3'd2 : 3'd1;
        default: beat_count = 3'd1;
      endcase
    end
  endfunction

  function conflict;
    input [1:0] ir;
    input [1:0] dr;
    begin
      conflict = ((ir == `CBD_RGN_FLASH) && ((dr == `CBD_RGN_FLASH) || (dr == `CBD_RGN_DRAM))) ||
        (((ir == `CBD_RGN_IRAM) || (ir == `CBD_RGN_DRAM)) &&
         ((dr == `CBD_RGN_IRAM) || (dr == `CBD_RGN_DRAM)));
    end
  endfunction

  function [3:0] lanes;
    input [1:0] dev;
    input [1:0] sz;
    begin
      if (dev == `CBD_DEV_8) lanes = 4'h1;
      else if (dev == `CBD_DEV_16) lanes = (sz == `CBD_SZ_8) ? 4'h1 : 4'h3;
      else lanes = (sz == `CBD_SZ_8) ? 4'h1 : (sz == `CBD_SZ_16) ? 4'h3 : 4'hF;
    end
  endfunction

  wire mirror_hit = (D_ADDR_IN == `CBD_OFS_STATUS_MIRROR);
  wire base_hit = (D_ADDR_IN == `CBD_OFS_DEBUG_BASE);
  wire internal_hit = mirror_hit || base_hit;
  wire start = (state_ff == ST_IDLE) && D_REQ_IN && !internal_hit;
  wire [2:0] step = (dev_ff == `CBD_DEV_8) ? 3'd1 : (dev_ff == `CBD_DEV_16) ? 3'd2 : 3'd4;
  wire last = (beat_ff + 3'd1 == beats_ff);
  // store word: upper byte zero, or status word when stacking
  wire [31:0] store_word = D_STACK_IN ? {PSW_IN, D_WDATA_IN[23:0]} :
    {`CBD_UPPER_PAD, D_WDATA_IN[23:0]};

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start) nxt_state = ST_BUSY;
      ST_BUSY: if (last) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= ST_IDLE;
      beat_ff <= 3'd0;
      beats_ff <= 3'd1;
      wdat_ff <= 32'h0000_0000;
      asm_ff <= 32'h0000_0000;
      addr_ff <= 24'h00_0000;
      wr_ff <= 1'b0;
      dev_ff <= 2'h0;
      stack_ff <= 1'b0;
      SYS_CYC_OUT <= 1'b0;
      SYS_WR_OUT <= 1'b0;
      SYS_ADDR_OUT <= 24'h00_0000;
      SYS_WDATA_OUT <= 8'h00;
      SYS_BE_OUT <= 4'h0;
      D_DONE_OUT <= 1'b0;
      D_RDATA_OUT <= 24'h00_0000;
      D_STACK_PSW_OUT <= 8'h00;
      I_STALL_OUT <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      D_DONE_OUT <= 1'b0;
      SYS_CYC_OUT <= 1'b0;
      SYS_WR_OUT <= 1'b0;
      if ((state_ff == ST_IDLE) && D_REQ_IN && internal_hit) begin
        D_DONE_OUT <= 1'b1;
        // mirror is read-only; a write is absorbed
        if (mirror_hit) begin
          D_RDATA_OUT <= {8'h00, `CBD_STATUS_HI_ZERO, PSW_IN};
        end else begin
          D_RDATA_OUT <= DEBUG_BASE;
        end
      end
      if (start) begin
        beat_ff <= 3'd0;
        beats_ff <= beat_count(D_DEV_IN, D_SIZE_IN);
        addr_ff <= D_ADDR_IN;
        wr_ff <= D_WR_IN;
        dev_ff <= D_DEV_IN;
        stack_ff <= D_STACK_IN;
        wdat_ff <= store_word;
        asm_ff <= 32'h0000_0000;
        SYS_CYC_OUT <= 1'b1;
        SYS_WR_OUT <= D_WR_IN;
        SYS_ADDR_OUT <= D_ADDR_IN;
        SYS_WDATA_OUT <= store_word[7:0];
        SYS_BE_OUT <= lanes(D_DEV_IN, D_SIZE_IN);
        I_STALL_OUT <= I_REQ_IN && conflict(I_RGN_IN, D_RGN_IN);
      end else if (state_ff == ST_BUSY) begin
        // gather this beat's bytes at their ascending lane
        case (beat_ff)
          3'd0: asm_ff <= (dev_ff == `CBD_DEV_8) ? {24'h00_0000, SYS_RDATA_IN[7:0]} : SYS_RDATA_IN;
          3'd1: asm_ff <= (dev_ff == `CBD_DEV_8) ? {asm_ff[31:16], SYS_RDATA_IN[7:0], asm_ff[7:0]} :
            {SYS_RDATA_IN[15:0], asm_ff[15:0]};
          3'd2: asm_ff <= {asm_ff[31:24], SYS_RDATA_IN[7:0], asm_ff[15:0]};
          default: asm_ff <= {SYS_RDATA_IN[7:0], asm_ff[23:0]};
        endcase
        if (last) begin
          I_STALL_OUT <= 1'b0;
          D_DONE_OUT <= 1'b1;
          if (beat_ff == 3'd3) begin
            D_RDATA_OUT <= asm_ff[23:0];
            D_STACK_PSW_OUT <= stack_ff ? SYS_RDATA_IN[7:0] : 8'h00;
          end else if (beat_ff == 3'd1) begin
            D_RDATA_OUT <= (dev_ff == `CBD_DEV_8) ? {8'h00, SYS_RDATA_IN[7:0], asm_ff[7:0]} :
              {SYS_RDATA_IN[7:0], asm_ff[15:0]};
            D_STACK_PSW_OUT <= (stack_ff && dev_ff != `CBD_DEV_8) ? SYS_RDATA_IN[15:8] : 8'h00;
          end else begin
            D_RDATA_OUT <= SYS_RDATA_IN[23:0];
            D_STACK_PSW_OUT <= stack_ff ? SYS_RDATA_IN[31:24] : 8'h00;
          end
        end else begin
          beat_ff <= beat_ff + 3'd1;
          SYS_CYC_OUT <= 1'b1;
          SYS_WR_OUT <= wr_ff;
          SYS_ADDR_OUT <= addr_ff + {21'h00_0000, step} * {21'h00_0000, beat_ff + 3'd1};
          SYS_WDATA_OUT <= (dev_ff == `CBD_DEV_8) ? wdat_ff[8*(beat_ff+3'd1) +: 8] : wdat_ff[23:16];
          SYS_BE_OUT <= (dev_ff == `CBD_DEV_8) ? 4'h1 : 4'h3;
        end
      end
    end
  end

  // debug work area storage, tied off: never written, address fixed at 0, read data cancels out
  cbd_dbg_area_mem #(.AW(4), .DW(32)) u_area (
    .clk_in(CLK_IN),
    .we_in(1'b0),
    .addr_in(4'h0),
    .wdata_in(32'h0000_0000),
    .rdata_out(mem_rdata)
  );

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      div_ff <= {DBG_CLK_DIV{1'b0}};
      brk_ff <= 1'b0;
      DBG_CLOCK_OUT <= 1'b0;
      DBG_STATE_OUT <= 1'b0;
      DBG_DATA_OUT <= 1'b0;
      DBG_DATA_OE_OUT <= 1'b0;
      DBG_PINS_ACTIVE_OUT <= 1'b1;
      DBG_IRQ_OUT <= 1'b0;
      FLASH_PROT_OUT <= 1'b1;
      DBG_FLASH_RDATA_OUT <= 32'h0000_0000;
      DBG_PROG_ERR_OUT <= 1'b0;
    end else begin
      div_ff <= div_ff + {{(DBG_CLK_DIV-1){1'b0}}, 1'b1};
      if (DBG_PINS_RELEASE_IN) begin
        DBG_PINS_ACTIVE_OUT <= 1'b0;
      end
      DBG_CLOCK_OUT <= DBG_PINS_ACTIVE_OUT && DBG_ACTIVE_IN && div_ff[DBG_CLK_DIV-1];
      DBG_STATE_OUT <= DBG_PINS_ACTIVE_OUT && DBG_ACTIVE_IN && DBG_STATE_IN[0];
      DBG_DATA_OE_OUT <= DBG_PINS_ACTIVE_OUT && DBG_SEND_IN;
      DBG_DATA_OUT <= DBG_SEND_BIT_IN;
      brk_ff <= DBG_PINS_ACTIVE_OUT && !DBG_SEND_IN && DBG_DATA_IN;
      DBG_IRQ_OUT <= DBG_PINS_ACTIVE_OUT && !DBG_SEND_IN && DBG_DATA_IN && !brk_ff;
      if (DBG_KEY_VALID_IN && DBG_KEY_IN == UNLOCK_KEY) begin
        FLASH_PROT_OUT <= 1'b0;
      end
      if (DBG_FLASH_RD_IN) begin
        DBG_FLASH_RDATA_OUT <= FLASH_PROT_OUT ? `CBD_UNDEF_READ : (SYS_RDATA_IN ^ mem_rdata ^ mem_rdata);
      end
      DBG_PROG_ERR_OUT <= DBG_FLASH_PROG_IN && FLASH_PROT_OUT;
    end
  end
endmodule // cbd_bus_debug

//--- include/cbd_consts.vh
// constants for the cpu bus access and debug support block
`ifndef CBD_CONSTS_VH
`define CBD_CONSTS_VH
`define CBD_SZ_8 2'h0
`define CBD_SZ_16 2'h1
`define CBD_SZ_32 2'h2
`define CBD_DEV_8 2'h0
`define CBD_DEV_16 2'h1
`define CBD_DEV_32 2'h2
`define CBD_RGN_OTHER 2'h0
`define CBD_RGN_FLASH 2'h1
`define CBD_RGN_IRAM 2'h2
`define CBD_RGN_DRAM 2'h3
`define CBD_OFS_STATUS_MIRROR 24'h00_4008
`define CBD_OFS_DEBUG_BASE 24'hFF_FF90
`define CBD_DEBUG_BASE_RST 24'h00_0FC0
`define CBD_UPPER_PAD 8'h00
`define CBD_STATUS_HI_ZERO 8'h00
`define CBD_DEBUG_HI_ZERO 8'h00
`define CBD_PROG_ERR_CODE 32'hDEAD_0001
`define CBD_UNDEF_READ 32'h0000_0000
`endif

//--- logic/cbd_dbg_area_mem.v
// small debug work area memory with registered read data
`timescale 1ns/10ps
module cbd_dbg_area_mem #(
  parameter AW = 4,
  parameter DW = 32
) (
  input wire clk_in,
  input wire we_in,
  input wire [AW-1:0] addr_in,
  input wire [DW-1:0] wdata_in,
  output reg [DW-1:0] rdata_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule // cbd_dbg_area_mem

//--- testbench/cbd_bus_monitor.sv
// concurrent checks on the bus and debug block ports
`timescale 1ns/10ps
module cbd_bus_monitor #(
  parameter [23:0] DEBUG_BASE = 24'h00_0FC0
) (
  input wire CLK_IN,
  input wire RST_IN,
  input wire D_WR_IN,
  input wire [23:0] D_ADDR_IN,
  input wire [1:0] D_DEV_IN,
  input wire [1:0] D_RGN_IN,
  input wire [1:0] I_RGN_IN,
  input wire [7:0] PSW_IN,
  input wire DBG_FLASH_RD_IN,
  input wire DBG_FLASH_PROG_IN,
  input wire SYS_CYC_OUT,
  input wire [23:0] SYS_ADDR_OUT,
  input wire D_DONE_OUT,
  input wire [23:0] D_RDATA_OUT,
  input wire I_STALL_OUT,
  input wire DBG_CLOCK_OUT,
  input wire DBG_STATE_OUT,
  input wire DBG_PINS_ACTIVE_OUT,
  input wire DBG_IRQ_OUT,
  input wire FLASH_PROT_OUT,
  input wire [31:0] DBG_FLASH_RDATA_OUT,
  input wire DBG_PROG_ERR_OUT
);
  wire clash = (I_RGN_IN == 2'h1 && D_RGN_IN[0]) || (I_RGN_IN[1] && D_RGN_IN[1]);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  reset_state_a: assert property ($past(RST_IN) |-> DBG_PINS_ACTIVE_OUT && FLASH_PROT_OUT &&
    !DBG_CLOCK_OUT && !DBG_STATE_OUT) else $error("bad state after reset");
  done_pulse_a: assert property (D_DONE_OUT |=> !D_DONE_OUT) else $error("done too long");
  addr_ascend_a: assert property (SYS_CYC_OUT && $past(SYS_CYC_OUT) && D_DEV_IN == 2'h0
    |-> SYS_ADDR_OUT == $past(SYS_ADDR_OUT) + 24'h00_0001) else $error("beat address order");
  mirror_read_a: assert property (D_DONE_OUT && !D_WR_IN && D_ADDR_IN == 24'h00_4008
    |-> D_RDATA_OUT == {16'h0000, PSW_IN}) else $error("status mirror value");
  base_read_a: assert property (D_DONE_OUT && !D_WR_IN && D_ADDR_IN == 24'hFF_FF90
    |-> D_RDATA_OUT == DEBUG_BASE) else $error("debug base value");
  stall_clash_a: assert property (I_STALL_OUT |-> clash) else $error("stall without clash");
  prot_sticky_a: assert property (!FLASH_PROT_OUT |=> !FLASH_PROT_OUT) else $error("protection back");
  prog_err_a: assert property (DBG_PROG_ERR_OUT |-> $past(DBG_FLASH_PROG_IN) &&
    $past(FLASH_PROT_OUT)) else $error("spurious program error");
  undef_read_a: assert property ($past(DBG_FLASH_RD_IN) && $past(FLASH_PROT_OUT)
    |-> DBG_FLASH_RDATA_OUT == 32'h0000_0000) else $error("protected read leaked");
  irq_pulse_a: assert property (DBG_IRQ_OUT |=> !DBG_IRQ_OUT) else $error("break pulse too long");
endmodule // cbd_bus_monitor

//--- testbench/cbd_dev_model.sv
// memory device behind the system bus, byte value tied to address
`timescale 1ns/10ps
module cbd_dev_model (
  input wire cyc_in,
  input wire [23:0] addr_in,
  output wire [31:0] rdata_out
);
  wire [7:0] b = addr_in[7:0] ^ 8'h3C;
  wire [31:0] word = {b + 8'h03, b + 8'h02, b + 8'h01, b};
  // answers in the same cycle, inverse pattern when not selected
  assign rdata_out = cyc_in ? word : ~word;
endmodule // cbd_dev_model

//--- testbench/test_cbd_bus_debug.sv
// self-checking bench for the bus and debug block
`timescale 1ns/10ps
module test_cbd_bus_debug;
  reg CLK_IN = 0, RST_IN = 1, D_REQ_IN = 0, D_WR_IN = 0, D_STACK_IN = 0, I_REQ_IN = 0, dbg_serial_io_drv = 0;
  reg DBG_PINS_RELEASE_IN = 0, DBG_FLASH_RD_IN = 0, DBG_FLASH_PROG_IN = 0, DBG_KEY_VALID_IN = 0;
  reg DBG_ACTIVE_IN = 0, DBG_SEND_IN = 0, DBG_SEND_BIT_IN = 0;
  reg [1:0] D_SIZE_IN = 0, D_DEV_IN = 0, D_RGN_IN = 0, I_RGN_IN = 0, DBG_STATE_IN = 0;
  reg [23:0] D_ADDR_IN = 0, first_addr;
  reg [31:0] D_WDATA_IN = 0, DBG_KEY_IN = 0;
  reg [7:0] PSW_IN = 8'hA5, last_wd;
  reg stall;
  wire SYS_CYC_OUT, SYS_WR_OUT, D_DONE_OUT, I_STALL_OUT, DBG_CLOCK_OUT, DBG_STATE_OUT, DBG_DATA_OUT, DBG_DATA_OE_OUT;
  wire DBG_PINS_ACTIVE_OUT, DBG_IRQ_OUT, FLASH_PROT_OUT, DBG_PROG_ERR_OUT;
  wire [23:0] SYS_ADDR_OUT, D_RDATA_OUT;
  wire [31:0] SYS_RDATA_IN, DBG_FLASH_RDATA_OUT;
  wire [7:0] SYS_WDATA_OUT, D_STACK_PSW_OUT;
  wire [3:0] SYS_BE_OUT;
  wire dbg_serial_io = DBG_DATA_OE_OUT ? DBG_DATA_OUT : dbg_serial_io_drv;
  integer num_errors = 0, checked = 0, cycles = 0, beats, d, s, k;
  localparam [29:0] TAB = {5'b01011, 5'b01111, 5'b10111, 5'b11101, 5'b01100, 5'b00010};
  cbd_dev_model dev (.cyc_in(SYS_CYC_OUT), .addr_in(SYS_ADDR_OUT), .rdata_out(SYS_RDATA_IN));
  cbd_bus_debug uut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .D_REQ_IN(D_REQ_IN), .D_WR_IN(D_WR_IN),
    .D_SIZE_IN(D_SIZE_IN), .D_ADDR_IN(D_ADDR_IN), .D_WDATA_IN(D_WDATA_IN), .D_STACK_IN(D_STACK_IN),
    .D_DEV_IN(D_DEV_IN), .D_RGN_IN(D_RGN_IN), .PSW_IN(PSW_IN), .I_REQ_IN(I_REQ_IN), .I_RGN_IN(I_RGN_IN),
    .SYS_RDATA_IN(SYS_RDATA_IN), .DBG_DATA_IN(dbg_serial_io), .DBG_PINS_RELEASE_IN(DBG_PINS_RELEASE_IN),
    .DBG_ACTIVE_IN(DBG_ACTIVE_IN), .DBG_STATE_IN(DBG_STATE_IN), .DBG_SEND_IN(DBG_SEND_IN),
    .DBG_SEND_BIT_IN(DBG_SEND_BIT_IN),
    .DBG_FLASH_RD_IN(DBG_FLASH_RD_IN), .DBG_FLASH_PROG_IN(DBG_FLASH_PROG_IN), .DBG_KEY_VALID_IN(DBG_KEY_VALID_IN),
    .DBG_KEY_IN(DBG_KEY_IN), .SYS_CYC_OUT(SYS_CYC_OUT), .SYS_WR_OUT(SYS_WR_OUT), .SYS_ADDR_OUT(SYS_ADDR_OUT),
    .SYS_WDATA_OUT(SYS_WDATA_OUT), .SYS_BE_OUT(SYS_BE_OUT), .D_DONE_OUT(D_DONE_OUT), .D_RDATA_OUT(D_RDATA_OUT),
    .D_STACK_PSW_OUT(D_STACK_PSW_OUT), .I_STALL_OUT(I_STALL_OUT), .DBG_CLOCK_OUT(DBG_CLOCK_OUT),
    .DBG_STATE_OUT(DBG_STATE_OUT), .DBG_DATA_OUT(DBG_DATA_OUT), .DBG_DATA_OE_OUT(DBG_DATA_OE_OUT),
    .DBG_PINS_ACTIVE_OUT(DBG_PINS_ACTIVE_OUT), .DBG_IRQ_OUT(DBG_IRQ_OUT), .FLASH_PROT_OUT(FLASH_PROT_OUT),
    .DBG_FLASH_RDATA_OUT(DBG_FLASH_RDATA_OUT), .DBG_PROG_ERR_OUT(DBG_PROG_ERR_OUT));
  initial begin
    forever #20 CLK_IN = ~CLK_IN;
  end
  task finish_test;
    begin
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge CLK_IN) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [1:0] sz, input [1:0] dv, input [1:0] rg, input [23:0] a, input [31:0] wd);
    integer n;
    begin
      D_WR_IN = w;
      D_SIZE_IN = sz;
      D_DEV_IN = dv;
      D_RGN_IN = rg;
      D_ADDR_IN = a;
      D_WDATA_IN = wd;
      D_REQ_IN = 1;
      beats = 0;
      stall = 0;
      for (n = 0; n < 20 && D_DONE_OUT !== 1'b1; n = n + 1) begin
        @(negedge CLK_IN);
        if (I_STALL_OUT === 1'b1) stall = 1;
        if (SYS_CYC_OUT === 1'b1) begin
          if (beats == 0) first_addr = SYS_ADDR_OUT;
          last_wd = SYS_WDATA_OUT;
          beats = beats + 1;
        end
      end
      D_REQ_IN = 0;
      @(negedge CLK_IN);
    end
  endtask
  task t_bus;
    begin
      for (d = 0; d < 3; d = d + 1) for (s = 0; s < 3; s = s + 1) begin
        acc(0, s, d, 0, 24'h00_0100, 0);
        check(beats, d == 2 ? 1 : d == 1 ? (s == 2 ? 2 : 1) : 1 << s);
        check(first_addr, 24'h00_0100);
        if (s == 2) check(D_RDATA_OUT, 24'h3E_3D3C);
      end
      acc(1, 2, 0, 0, 24'h00_0200, 32'hFFA1_B2C3);
      check(last_wd, 8'h00);
      D_STACK_IN = 1;
      acc(1, 2, 0, 0, 24'h00_0300, 32'h0000_1234);
      check(last_wd, 8'hA5);
      acc(0, 2, 2, 0, 24'h00_0300, 0);
      D_STACK_IN = 0;
      check(D_STACK_PSW_OUT, 8'h3F);
      check(D_RDATA_OUT, 24'h3E_3D3C);
    end
  endtask
  task t_regs;
    begin
      acc(1, 1, 1, 0, 24'h00_4008, 32'h0000_FFFF);
      acc(0, 1, 1, 0, 24'h00_4008, 0);
      check(D_RDATA_OUT, 24'h00_00A5);
      acc(0, 2, 2, 0, 24'hFF_FF90, 0);
      check(D_RDATA_OUT, 24'h00_0FC0);
      I_REQ_IN = 1;
      for (k = 0; k < 6; k = k + 1) begin
        I_RGN_IN = TAB[5 * k + 3 +: 2];
        acc(0, 1, 0, TAB[5 * k + 1 +: 2], 24'h00_0400, 0);
        check(stall, TAB[5 * k]);
      end
      I_REQ_IN = 0;
    end
  endtask
  task t_debug;
    begin
      check({DBG_PINS_ACTIVE_OUT, FLASH_PROT_OUT, DBG_CLOCK_OUT, DBG_STATE_OUT}, 4'hC);
      DBG_ACTIVE_IN = 1;
      DBG_STATE_IN = 1;
      DBG_SEND_IN = 1;
      DBG_SEND_BIT_IN = 1;
      s = 0;
      repeat (16) begin
        @(negedge CLK_IN);
        s = s | DBG_CLOCK_OUT;
      end
      check(s, 1);
      check({DBG_STATE_OUT, DBG_DATA_OE_OUT, DBG_DATA_OUT, DBG_IRQ_OUT}, 4'hE);
      DBG_SEND_BIT_IN = 0;
      @(negedge CLK_IN);
      DBG_ACTIVE_IN = 0;
      DBG_STATE_IN = 0;
      DBG_SEND_IN = 0;
      @(negedge CLK_IN);
      check({DBG_STATE_OUT, DBG_DATA_OE_OUT, DBG_CLOCK_OUT}, 3'b000);
      DBG_FLASH_PROG_IN = 1;
      DBG_FLASH_RD_IN = 1;
      @(negedge CLK_IN);
      DBG_FLASH_PROG_IN = 0;
      DBG_FLASH_RD_IN = 0;
      check(DBG_PROG_ERR_OUT, 1);
      check(DBG_FLASH_RDATA_OUT, 32'h0000_0000);
      for (k = 0; k < 2; k = k + 1) begin
        DBG_KEY_IN = 32'h1234_5679 - k;
        DBG_KEY_VALID_IN = 1;
        @(negedge CLK_IN);
        DBG_KEY_VALID_IN = 0;
        check(FLASH_PROT_OUT, 1 - k);
      end
      DBG_FLASH_PROG_IN = 1;
      DBG_FLASH_RD_IN = 1;
      dbg_serial_io_drv = 1;
      @(negedge CLK_IN);
      DBG_FLASH_PROG_IN = 0;
      DBG_FLASH_RD_IN = 0;
      dbg_serial_io_drv = 0;
      check({DBG_PROG_ERR_OUT, DBG_IRQ_OUT}, 2'b01);
      check(DBG_FLASH_RDATA_OUT, 32'hC0C1_C2C3);
      DBG_PINS_RELEASE_IN = 1;
      @(negedge CLK_IN);
      DBG_PINS_RELEASE_IN = 0;
      check(DBG_PINS_ACTIVE_OUT, 0);
      RST_IN = 1;
      @(negedge CLK_IN);
      RST_IN = 0;
      check(FLASH_PROT_OUT, 1);
    end
  endtask
  initial begin
    repeat (3) @(negedge CLK_IN);
    RST_IN = 0;
    t_debug;
    t_bus;
    t_regs;
    finish_test;
  end
endmodule // test_cbd_bus_debug
bind cbd_bus_debug cbd_bus_monitor #(.DEBUG_BASE(DEBUG_BASE)) mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .D_WR_IN(D_WR_IN), .D_ADDR_IN(D_ADDR_IN), .D_DEV_IN(D_DEV_IN), .D_RGN_IN(D_RGN_IN), .I_RGN_IN(I_RGN_IN),
  .PSW_IN(PSW_IN), .DBG_FLASH_RD_IN(DBG_FLASH_RD_IN), .DBG_FLASH_PROG_IN(DBG_FLASH_PROG_IN),
  .SYS_CYC_OUT(SYS_CYC_OUT), .SYS_ADDR_OUT(SYS_ADDR_OUT), .D_DONE_OUT(D_DONE_OUT), .D_RDATA_OUT(D_RDATA_OUT),
  .I_STALL_OUT(I_STALL_OUT), .DBG_CLOCK_OUT(DBG_CLOCK_OUT), .DBG_STATE_OUT(DBG_STATE_OUT),
  .DBG_PINS_ACTIVE_OUT(DBG_PINS_ACTIVE_OUT), .DBG_IRQ_OUT(DBG_IRQ_OUT), .FLASH_PROT_OUT(FLASH_PROT_OUT),
  .DBG_FLASH_RDATA_OUT(DBG_FLASH_RDATA_OUT), .DBG_PROG_ERR_OUT(DBG_PROG_ERR_OUT));
